// File: design/bcf_port_control.sv
// port control, queues and mailboxes of the bidirectional clocked queue
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "bcf_params.svh"

// ****************************************
// one direction of storage with its flags
// ****************************************
module bcf_queue #(
  parameter int WIDTH = `BCF_WIDTH,
  parameter int DEPTH = `BCF_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic qrst,
  input wire logic wr_tick,
  input wire logic rd_tick,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] empty_thr,
  input wire logic [AW-1:0] full_thr,
  output logic in_ready,
  output logic out_ready,
  output logic af_n,
  output logic ae_n,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, rs1, rs2, ws1, ws2;
  logic [AW:0] next_wr, next_rd, wcount, rcount;
  logic arm, wr_go, load, next_valid;

  always_comb begin
    wr_go = wr_tick & wr_en & in_ready;
    next_wr = wr_ptr + (AW+1)'(wr_go);
    wcount = next_wr - rs2;
    load = rd_tick && (!out_ready || rd_en) && (ws2 != rd_ptr);
    next_rd = rd_ptr + (AW+1)'(load);
    next_valid = load | (out_ready & ~(rd_tick & rd_en));
    rcount = ws2 - next_rd + (AW+1)'(next_valid);
  end

  always_ff @(posedge pclk) begin
    if (wr_go) begin
      mem[wr_ptr[AW-1:0]] <= wr_data;
    end
  end

  // writer side: pointer, full and almost-full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rs1 <= '0;
      rs2 <= '0;
      arm <= 1'b0;
      in_ready <= 1'b0;
      af_n <= 1'b1;
    end else if (qrst) begin
      wr_ptr <= '0;
      rs1 <= '0;
      rs2 <= '0;
      arm <= 1'b0;
      in_ready <= 1'b0;
      af_n <= 1'b1;
    end else if (wr_tick) begin
      wr_ptr <= next_wr;
      rs1 <= rd_ptr;
      rs2 <= rs1;
      arm <= 1'b1;
      in_ready <= arm && (wcount != FULL);
      af_n <= (FULL - wcount) > {1'b0, full_thr};
    end
  end

  // reader side: two-edge pointer view, output register load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr <= '0;
      ws1 <= '0;
      ws2 <= '0;
      out_ready <= 1'b0;
      out_data <= '0;
      ae_n <= 1'b0;
    end else if (qrst) begin
      rd_ptr <= '0;
      ws1 <= '0;
      ws2 <= '0;
      out_ready <= 1'b0;
      ae_n <= 1'b0;
    end else if (rd_tick) begin
      ws1 <= wr_ptr;
      ws2 <= ws1;
      rd_ptr <= next_rd;
      out_ready <= next_valid;
      ae_n <= rcount > {1'b0, empty_thr};
      if (load) begin
        out_data <= mem[rd_ptr[AW-1:0]];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= '0;
    end else begin
      level <= qrst ? '0 : wr_ptr - rd_ptr;
    end
  end
endmodule // bcf_queue

module bcf_port_control #(
  parameter int WIDTH = `BCF_WIDTH,
  parameter int DEPTH = `BCF_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic left_port_clock,
  input wire logic left_port_select_n,
  input wire logic left_port_enable,
  input wire logic left_direction_select,
  input wire logic left_mailbox_select,
  input wire logic [WIDTH-1:0] left_data_in,
  output logic [WIDTH-1:0] left_data_out,
  output logic left_data_oe_n,
  output logic left_input_ready,
  output logic left_output_ready,
  output logic left_almost_full_n,
  output logic left_almost_empty_n,
  input wire logic right_port_clock,
  input wire logic right_port_select_n,
  input wire logic right_port_enable,
  input wire logic right_direction_select,
  input wire logic right_mailbox_select,
  input wire logic [WIDTH-1:0] right_data_in,
  output logic [WIDTH-1:0] right_data_out,
  output logic right_data_oe_n,
  output logic right_input_ready,
  output logic right_output_ready,
  output logic right_almost_full_n,
  output logic right_almost_empty_n,
  output logic fwd_mailbox_empty_flag,
  output logic rev_mailbox_empty_flag,
  input wire logic fwd_queue_reset_n,
  input wire logic rev_queue_reset_n,
  input wire logic offset_choice_lo,
  input wire logic offset_choice_hi
);
  import bcf_pkg::*;

  bcf_port_t lp, rp;
  bcf_prog_t prog;
  logic lclk_q, rclk_q, frst_q, rrst_q, fq_rst_n, rq_rst_n, frise, rrise;
  logic l_wr, l_rd, r_wr, r_rd, prog_wr, fwd_wr_en;
  logic [1:0] ctrl;
  logic [AW-1:0] x1, y1, x2, y2, preset;
  logic [AW:0] fwd_level, rev_level;
  logic [WIDTH-1:0] fwd_mailbox, rev_mailbox, fwd_out, rev_out;
  logic [31:0] rd_mux;
  logic bad_addr;

  // ****************************************
  // port clock edges and access qualification
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lclk_q <= 1'b0;
      rclk_q <= 1'b0;
      frst_q <= 1'b0;
      rrst_q <= 1'b0;
    end else begin
      lclk_q <= left_port_clock;
      rclk_q <= right_port_clock;
      frst_q <= fq_rst_n;
      rrst_q <= rq_rst_n;
    end
  end

  always_comb begin
    fq_rst_n = fwd_queue_reset_n & ~ctrl[0];
    rq_rst_n = rev_queue_reset_n & ~ctrl[1];
    frise = fq_rst_n & ~frst_q;
    rrise = rq_rst_n & ~rrst_q;
    lp = '{tick: left_port_clock & ~lclk_q, sel_n: left_port_select_n, en: left_port_enable,
           wr: left_direction_select, mbx: left_mailbox_select};
    rp = '{tick: right_port_clock & ~rclk_q, sel_n: right_port_select_n, en: right_port_enable,
           wr: ~right_direction_select, mbx: right_mailbox_select};
    l_wr = lp.tick & ~lp.sel_n & lp.en & lp.wr;
    l_rd = lp.tick & ~lp.sel_n & lp.en & ~lp.wr;
    r_wr = rp.tick & ~rp.sel_n & rp.en & rp.wr;
    r_rd = rp.tick & ~rp.sel_n & rp.en & ~rp.wr;
    prog_wr = l_wr & ~lp.mbx & left_input_ready & (prog != BCF_PRG_DONE);
    fwd_wr_en = ~lp.mbx & (prog == BCF_PRG_DONE) & l_wr;
    unique case ({offset_choice_hi, offset_choice_lo})
      2'b11: preset = AW'(`BCF_OFS_BOTH);
      2'b10: preset = AW'(`BCF_OFS_HI);
      default: preset = AW'(`BCF_OFS_LO);
    endcase
  end

  // ****************************************
  // offset capture and programming
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog <= BCF_PRG_DONE;
      x1 <= AW'(`BCF_OFS_RESET);
      y1 <= AW'(`BCF_OFS_RESET);
      x2 <= AW'(`BCF_OFS_RESET);
      y2 <= AW'(`BCF_OFS_RESET);
    end else if (frise && rrise && !offset_choice_hi && !offset_choice_lo) begin
      prog <= BCF_PRG_X1;
    end else begin
      if (frise && (offset_choice_hi || offset_choice_lo)) begin
        x1 <= preset;
        y1 <= preset;
      end
      if (rrise && (offset_choice_hi || offset_choice_lo)) begin
        x2 <= preset;
        y2 <= preset;
      end
      if (prog_wr) begin
        unique case (prog)
          BCF_PRG_X1: begin
            x1 <= left_data_in[AW-1:0];
            prog <= BCF_PRG_Y1;
          end
          BCF_PRG_Y1: begin
            y1 <= left_data_in[AW-1:0];
            prog <= BCF_PRG_X2;
          end
          BCF_PRG_X2: begin
            x2 <= left_data_in[AW-1:0];
            prog <= BCF_PRG_Y2;
          end
          BCF_PRG_Y2: begin
            y2 <= left_data_in[AW-1:0];
            prog <= BCF_PRG_DONE;
          end
          default: prog <= BCF_PRG_DONE;
        endcase
      end
    end
  end

  // ****************************************
  // queues
  // ****************************************
  bcf_queue #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_fwd (
    .pclk(pclk), .presetn(presetn), .qrst(~fq_rst_n),
    .wr_tick(lp.tick), .rd_tick(rp.tick),
    .wr_en(fwd_wr_en), .wr_data(left_data_in),
    .rd_en(r_rd & ~rp.mbx & right_output_ready),
    .empty_thr(x1), .full_thr(y1),
    .in_ready(left_input_ready), .out_ready(right_output_ready),
    .af_n(left_almost_full_n), .ae_n(right_almost_empty_n),
    .out_data(fwd_out), .level(fwd_level)
  );

  bcf_queue #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_rev (
    .pclk(pclk), .presetn(presetn), .qrst(~rq_rst_n),
    .wr_tick(rp.tick), .rd_tick(lp.tick),
    .wr_en(r_wr & ~rp.mbx), .wr_data(right_data_in),
    .rd_en(l_rd & ~lp.mbx & left_output_ready),
    .empty_thr(x2), .full_thr(y2),
    .in_ready(right_input_ready), .out_ready(left_output_ready),
    .af_n(right_almost_full_n), .ae_n(left_almost_empty_n),
    .out_data(rev_out), .level(rev_level)
  );

  // ****************************************
  // mailboxes and their flags
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_mailbox <= '0;
      fwd_mailbox_empty_flag <= 1'b1;
    end else if (!fq_rst_n) begin
      fwd_mailbox_empty_flag <= 1'b1;
    end else if (l_wr && lp.mbx && fwd_mailbox_empty_flag) begin
      fwd_mailbox <= left_data_in;
      fwd_mailbox_empty_flag <= 1'b0;
    end else if (r_rd && rp.mbx) begin
      fwd_mailbox_empty_flag <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rev_mailbox <= '0;
      rev_mailbox_empty_flag <= 1'b1;
    end else if (!rq_rst_n) begin
      rev_mailbox_empty_flag <= 1'b1;
    end else if (r_wr && rp.mbx && rev_mailbox_empty_flag) begin
      rev_mailbox <= right_data_in;
      rev_mailbox_empty_flag <= 1'b0;
    end else if (l_rd && lp.mbx) begin
      rev_mailbox_empty_flag <= 1'b1;
    end
  end

  // ****************************************
  // data drivers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_data_out <= '0;
      left_data_oe_n <= 1'b1;
      right_data_out <= '0;
      right_data_oe_n <= 1'b1;
    end else begin
      left_data_out <= left_mailbox_select ? rev_mailbox : rev_out;
      left_data_oe_n <= left_port_select_n | left_direction_select;
      right_data_out <= right_mailbox_select ? fwd_mailbox : fwd_out;
      right_data_oe_n <= right_port_select_n | ~right_direction_select;
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  always_comb begin
    bad_addr = 1'b0;
    rd_mux = '0;
    unique case (paddr)
      `BCF_REG_CTRL: rd_mux = {30'h0, ctrl};
      `BCF_REG_STATUS: rd_mux = {20'h0, prog == BCF_PRG_DONE, fwd_mailbox_empty_flag,
                                 rev_mailbox_empty_flag, left_input_ready, left_output_ready,
                                 left_almost_full_n, left_almost_empty_n, right_input_ready,
                                 right_output_ready, right_almost_full_n, right_almost_empty_n,
                                 fq_rst_n & rq_rst_n};
      `BCF_REG_FWD_LEVEL: rd_mux = 32'(fwd_level);
      `BCF_REG_REV_LEVEL: rd_mux = 32'(rev_level);
      `BCF_REG_FWD_OFS: rd_mux = {7'h0, y1, 7'h0, x1};
      `BCF_REG_REV_OFS: rd_mux = {7'h0, y2, 7'h0, x2};
      default: bad_addr = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      ctrl <= `BCF_CTRL_RESET;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & bad_addr;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0 : rd_mux;
      end
      if (psel && penable && pready && pwrite && paddr == `BCF_REG_CTRL) begin
        ctrl <= pwdata[1:0];
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  left_drive_off_a: assert property (left_port_select_n |=> left_data_oe_n)
    else $error("left drivers on while deselected");
  right_drive_off_a: assert property (right_port_select_n |=> right_data_oe_n)
    else $error("right drivers on while deselected");
  left_ready_hold_a: assert property (!lp.tick && fq_rst_n && $past(fq_rst_n) |=> $stable(left_input_ready))
    else $error("left input ready moved without left edge");
  right_ready_hold_a: assert property (!rp.tick && rq_rst_n && $past(rq_rst_n) |=> $stable(right_input_ready))
    else $error("right input ready moved without right edge");
  fwd_reset_ready_a: assert property (!fq_rst_n |=> !left_input_ready && fwd_mailbox_empty_flag)
    else $error("forward reset did not clear ready or set mailbox flag");
  rev_reset_ready_a: assert property (!rq_rst_n |=> !right_input_ready && !left_output_ready)
    else $error("reverse reset did not clear flags");
  fwd_mail_take_a: assert property (fq_rst_n && l_wr && lp.mbx && fwd_mailbox_empty_flag
                                    |=> !fwd_mailbox_empty_flag && fwd_mailbox == $past(left_data_in))
    else $error("forward mailbox write not taken");
  fwd_mail_block_a: assert property (!fwd_mailbox_empty_flag |=> $stable(fwd_mailbox))
    else $error("forward mailbox overwritten while full");
  rev_mail_free_a: assert property (rq_rst_n && l_rd && lp.mbx && !(r_wr && rp.mbx)
                                    |=> rev_mailbox_empty_flag)
    else $error("reverse mailbox flag not released by left read");
  preset_big_a: assert property (frise && offset_choice_hi && offset_choice_lo
                                 |=> x1 == AW'(`BCF_OFS_BOTH) && y1 == AW'(`BCF_OFS_BOTH))
    else $error("forward preset offset wrong");
  prog_start_a: assert property (frise && rrise && !offset_choice_hi && !offset_choice_lo
                                 |=> prog == BCF_PRG_X1)
    else $error("offset programming not started");

  fwd_data_c: cover property (l_wr && !lp.mbx ##[1:60] right_output_ready);
  mail_trip_c: cover property (l_wr && lp.mbx ##[1:40] r_rd && rp.mbx);
  prog_done_c: cover property (prog == BCF_PRG_Y2 ##1 prog == BCF_PRG_DONE);
endmodule // bcf_port_control
`default_nettype wire

// File: design/bcf_params.svh
// constants for the bidirectional clocked queue port control
`ifndef BCF_PARAMS_SVH
`define BCF_PARAMS_SVH
`define BCF_DEPTH 512
`define BCF_WIDTH 36
`define BCF_OFS_BOTH 9'h040
`define BCF_OFS_HI 9'h010
`define BCF_OFS_LO 9'h008
`define BCF_OFS_RESET 9'h008
`define BCF_REG_CTRL 12'h000
`define BCF_REG_STATUS 12'h004
`define BCF_REG_FWD_LEVEL 12'h008
`define BCF_REG_REV_LEVEL 12'h00c
`define BCF_REG_FWD_OFS 12'h010
`define BCF_REG_REV_OFS 12'h014
`define BCF_CTRL_RESET 2'h0
`endif

// File: design/bcf_pkg.sv
// types for the bidirectional clocked queue port control
package bcf_pkg;
  typedef struct packed {
    logic tick;
    logic sel_n;
    logic en;
    logic wr;
    logic mbx;
  } bcf_port_t;
  typedef enum logic [4:0] {
    BCF_PRG_X1 = 5'b00001,
    BCF_PRG_Y1 = 5'b00010,
    BCF_PRG_X2 = 5'b00100,
    BCF_PRG_Y2 = 5'b01000,
    BCF_PRG_DONE = 5'b10000
  } bcf_prog_t;
endpackage

// File: verification/bcf_port_agent.sv
// bus-side model of the logic on one port of the queue device
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// port master with free-running port clock
// ****************************************
module bcf_port_agent #(
  parameter int HALF = 4,
  parameter int PHASE = 0,
  parameter logic WR = 1'b1
) (
  input wire logic pclk,
  output logic port_clock,
  output logic sel_n,
  output logic en,
  output logic dir,
  output logic mbx,
  output logic [35:0] wdata,
  input wire logic [35:0] rdata,
  input wire logic oe_n
);
  int cnt = PHASE;

  initial begin
    port_clock = 1'b0;
    sel_n = 1'b1;
    en = 1'b0;
    dir = WR;
    mbx = 1'b0;
    wdata = 36'h0;
  end

  always @(posedge pclk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) port_clock <= ~port_clock;
  end

  // one access: set up while the port clock is low, held through its rise
  task automatic acc(input logic wr, input logic sel_mbx, input logic ena, input logic [35:0] d,
                     output logic [35:0] q, output logic oe);
    @(negedge port_clock);
    sel_n <= 1'b0;
    en <= ena;
    dir <= wr ? WR : ~WR;
    mbx <= sel_mbx;
    if (wr) wdata <= d;
    @(posedge port_clock);
    @(posedge pclk);
    q = rdata;
    oe = oe_n;
    sel_n <= 1'b1;
    en <= 1'b0;
    dir <= WR;
    wdata <= ~wdata;
  endtask

  // wait for port clock rises, then let the registered flags land
  task automatic edges(input int n);
    repeat (n) @(posedge port_clock);
    repeat (2) @(posedge pclk);
    #1;
  endtask
endmodule // bcf_port_agent

`default_nettype wire

// File: verification/bcf_port_control_test.sv
// self-checking bench for the bidirectional clocked queue port control
`timescale 1ns/10ps
`default_nettype none
`include "bcf_params.svh"
`define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, ex, sn); end end

module bcf_port_control_test;
  import bcf_pkg::*;
  logic pclk = 1'b0, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, oe, err;
  logic left_port_clock, left_port_select_n, left_port_enable, left_direction_select, left_mailbox_select;
  logic right_port_clock, right_port_select_n, right_port_enable, right_direction_select, right_mailbox_select;
  logic [35:0] left_data_in, left_data_out, right_data_in, right_data_out, q;
  logic left_data_oe_n, left_input_ready, left_output_ready, left_almost_full_n, left_almost_empty_n;
  logic right_data_oe_n, right_input_ready, right_output_ready, right_almost_full_n, right_almost_empty_n;
  logic fwd_mailbox_empty_flag, rev_mailbox_empty_flag;
  logic fwd_queue_reset_n, rev_queue_reset_n, offset_choice_lo, offset_choice_hi;
  int n_fail = 0, compares = 0, n;

  bcf_port_control bcf_port_control_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .left_port_clock, .left_port_select_n, .left_port_enable, .left_direction_select, .left_mailbox_select,
    .left_data_in, .left_data_out, .left_data_oe_n, .left_input_ready, .left_output_ready,
    .left_almost_full_n, .left_almost_empty_n,
    .right_port_clock, .right_port_select_n, .right_port_enable, .right_direction_select,
    .right_mailbox_select, .right_data_in, .right_data_out, .right_data_oe_n, .right_input_ready,
    .right_output_ready, .right_almost_full_n, .right_almost_empty_n,
    .fwd_mailbox_empty_flag, .rev_mailbox_empty_flag, .fwd_queue_reset_n, .rev_queue_reset_n,
    .offset_choice_lo, .offset_choice_hi
  );
  bcf_port_agent #(.HALF(4), .PHASE(0), .WR(1'b1)) left_agent (
    .pclk, .port_clock(left_port_clock), .sel_n(left_port_select_n), .en(left_port_enable),
    .dir(left_direction_select), .mbx(left_mailbox_select), .wdata(left_data_in),
    .rdata(left_data_out), .oe_n(left_data_oe_n)
  );
  bcf_port_agent #(.HALF(4), .PHASE(2), .WR(1'b0)) right_agent (
    .pclk, .port_clock(right_port_clock), .sel_n(right_port_select_n), .en(right_port_enable),
    .dir(right_direction_select), .mbx(right_mailbox_select), .wdata(right_data_in),
    .rdata(right_data_out), .oe_n(right_data_oe_n)
  );

  always #5 pclk = ~pclk;

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic slverr);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    @(posedge pclk);
    #1;
  endtask

  // reset both queues with choice code 3-i, then check flags and offsets
  task automatic qreset(input int i);
    logic [8:0] ofs;
    logic [31:0] ef, er;
    @(posedge pclk);
    fwd_queue_reset_n <= 1'b0;
    rev_queue_reset_n <= 1'b0;
    {offset_choice_hi, offset_choice_lo} <= 2'(3 - i);
    repeat (40) @(posedge pclk);
    @(negedge left_port_clock);
    fwd_queue_reset_n <= 1'b1;
    rev_queue_reset_n <= 1'b1;
    fork
      begin
        left_agent.edges(1);
        `CHK("left input early", 1'b0, left_input_ready)
        left_agent.edges(1);
        `CHK("left input", 1'b1, left_input_ready)
      end
      begin
        right_agent.edges(1);
        `CHK("right input early", 1'b0, right_input_ready)
        right_agent.edges(1);
        `CHK("right input", 1'b1, right_input_ready)
      end
    join
    @(posedge pclk);
    {offset_choice_hi, offset_choice_lo} <= 2'(i);
    ofs = (i == 0) ? `BCF_OFS_BOTH : (i == 1) ? `BCF_OFS_HI : `BCF_OFS_LO;
    ef = {2{7'h0, ofs}};
    er = ef;
    if (i == 3) begin
      for (int k = 0; k < 4; k++) left_agent.acc(1'b1, 1'b0, 1'b1, 36'(k + 5), q, oe);
      ef = 32'h0006_0005;
      er = 32'h0008_0007;
      right_agent.edges(4);
      `CHK("no data stored", 1'b0, right_output_ready)
    end
    apb(1'b0, `BCF_REG_FWD_OFS, 32'h0, rd, err);
    `CHK("fwd offsets", ef, rd)
    apb(1'b0, `BCF_REG_REV_OFS, 32'h0, rd, err);
    `CHK("rev offsets", er, rd)
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fwd_queue_reset_n, rev_queue_reset_n, offset_choice_hi, offset_choice_lo} = 4'b0011;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) qreset(i);
    left_agent.acc(1'b1, 1'b1, 1'b1, 36'ha_bcde_f012, q, oe);
    `CHK("left write oe_n", 1'b1, oe)
    settle();
    `CHK("fwd mail flag", 1'b0, fwd_mailbox_empty_flag)
    left_agent.acc(1'b1, 1'b1, 1'b1, 36'h1, q, oe);
    right_agent.acc(1'b0, 1'b1, 1'b1, 36'h0, q, oe);
    `CHK("fwd mail word", 36'ha_bcde_f012, q)
    `CHK("right read oe_n", 1'b0, oe)
    settle();
    `CHK("fwd mail free", 1'b1, fwd_mailbox_empty_flag)
    right_agent.acc(1'b1, 1'b1, 1'b1, 36'h3_1415_9265, q, oe);
    settle();
    `CHK("rev mail flag", 1'b0, rev_mailbox_empty_flag)
    right_agent.acc(1'b1, 1'b1, 1'b1, 36'h1, q, oe);
    left_agent.acc(1'b0, 1'b1, 1'b1, 36'h0, q, oe);
    `CHK("rev mail word", 36'h3_1415_9265, q)
    `CHK("left read oe_n", 1'b0, oe)
    settle();
    `CHK("rev mail free", 1'b1, rev_mailbox_empty_flag)
    `CHK("left idle oe_n", 1'b1, left_data_oe_n)
    `CHK("right idle oe_n", 1'b1, right_data_oe_n)
    left_agent.acc(1'b1, 1'b0, 1'b0, 36'h7, q, oe);
    left_agent.acc(1'b1, 1'b0, 1'b1, 36'h1_2345_6789, q, oe);
    right_agent.edges(2);
    `CHK("right ready early", 1'b0, right_output_ready)
    right_agent.edges(1);
    `CHK("right ready", 1'b1, right_output_ready)
    right_agent.acc(1'b0, 1'b0, 1'b1, 36'h0, q, oe);
    `CHK("fwd word", 36'h1_2345_6789, q)
    right_agent.acc(1'b1, 1'b0, 1'b1, 36'h2_0000_0002, q, oe);
    left_agent.edges(2);
    `CHK("left ready early", 1'b0, left_output_ready)
    left_agent.edges(1);
    `CHK("left ready", 1'b1, left_output_ready)
    left_agent.acc(1'b0, 1'b0, 1'b1, 36'h0, q, oe);
    `CHK("rev word", 36'h2_0000_0002, q)
    left_agent.edges(1);
    `CHK("rev empty", 1'b0, left_output_ready)
    n = 0;
    while (left_input_ready === 1'b1 && n < 600) begin
      left_agent.acc(1'b1, 1'b0, 1'b1, 36'(n), q, oe);
      settle();
      n++;
    end
    `CHK("fill count", 32'(`BCF_DEPTH + 1), 32'(n))
    left_agent.acc(1'b1, 1'b0, 1'b1, 36'hf_ffff_ffff, q, oe);
    `CHK("full almost full", 1'b0, left_almost_full_n)
    `CHK("full almost empty", 1'b1, right_almost_empty_n)
    apb(1'b0, `BCF_REG_FWD_LEVEL, 32'h0, rd, err);
    `CHK("fwd level", 32'(`BCF_DEPTH), rd)
    for (int k = 0; k <= `BCF_DEPTH; k++) begin
      while (right_output_ready !== 1'b1) right_agent.edges(1);
      right_agent.acc(1'b0, 1'b0, 1'b1, 36'h0, q, oe);
      settle();
      `CHK("drain word", 36'(k), q)
    end
    right_agent.edges(3);
    `CHK("drained", 1'b0, right_output_ready)
    apb(1'b0, `BCF_REG_STATUS, 32'h0, rd, err);
    `CHK("status flags", 12'hf55, rd[11:0])
    apb(1'b0, 12'h020, 32'h0, rd, err);
    `CHK("unmapped error", 1'b1, err)
    left_agent.acc(1'b1, 1'b1, 1'b1, 36'h5, q, oe);
    settle();
    `CHK("mail before reset", 1'b0, fwd_mailbox_empty_flag)
    apb(1'b1, `BCF_REG_CTRL, 32'h3, rd, err);
    repeat (40) @(posedge pclk);
    apb(1'b0, `BCF_REG_CTRL, 32'h0, rd, err);
    `CHK("ctrl readback", 32'h3, rd)
    `CHK("mail after reset", 1'b1, fwd_mailbox_empty_flag)
    `CHK("left input in reset", 1'b0, left_input_ready)
    `CHK("right input in reset", 1'b0, right_input_ready)
    apb(1'b1, `BCF_REG_CTRL, 32'h0, rd, err);
    end_of_test();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end
endmodule // bcf_port_control_test

`default_nettype wire
